// ---- ccr_chk.sv ----
// Link assertions for the clock ratio controller.
`timescale 1ns/1ps
`default_nettype none
module ccr_chk
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Request side
  input  wire logic              req_valid,
  input  wire logic              req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [ID_W-1:0]   req_id,
  // Response side
  input  wire logic              rsp_valid,
  input  wire logic [DATA_W-1:0] rsp_rdata
);
  // ****************************************
  // Shadow of privilege and prescale control
  // ****************************************
  typedef struct packed {
    logic [17:0] priv;
    logic [8:0]  ps;
  } ccr_shadow_s;
  ccr_shadow_s sh_q;
  ccr_shadow_s sh_d;
  logic        wr_ok;

  assign wr_ok = req_valid && req_write && sh_q.priv[req_id < 3'd6 ? 5'(req_id) : 5'(req_id) + 5'd10];

  always_comb
  begin
    sh_d = sh_q;
    if (wr_ok && req_addr == OFF_PRIV)
      sh_d.priv = req_wdata[17:0] & 18'h3_003F;
    if (wr_ok && req_addr == OFF_PRESCALE)
    begin
      sh_d.ps[8] = req_wdata[8];
      if (sh_q.ps[8] || req_wdata[8])
        sh_d.ps[7:0] = req_wdata[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sh_q <= '{priv: 18'h3_003F, ps: 9'h000};
    else
      sh_q <= sh_d;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [ADDR_W-1:0] a);
    req_valid && !req_write && req_addr == a;
  endsequence
  sequence s_rd_blk(logic [ADDR_W-1:0] b);
    req_valid && !req_write && (req_addr & BLOCK_MASK) == b;
  endsequence

  property p_rsp_next; req_valid |=> rsp_valid; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no response after request");
  property p_rsp_cause; rsp_valid |-> $past(req_valid); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("response without request");
  property p_wr_zero; req_valid && req_write |=> rsp_rdata == '0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answered with data");
  property p_ready; req_valid |-> req_ready; endproperty
  a_ready: assert property (p_ready) else $error("request not accepted");
  property p_unmapped; s_rd_blk(BLOCK_MASK) |=> rsp_rdata == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("spare block read not zero");
  property p_io_coherence_unit_local; s_rd_blk(LOCAL_BASE) and req_id[2:1] == 2'b11 |=> rsp_rdata == '0; endproperty
  a_io_coherence_unit_local: assert property (p_io_coherence_unit_local) else $error("io unit local read not zero");
  property p_priv_rd; s_rd(OFF_PRIV) |=> rsp_rdata == {46'h0, $past(sh_q.priv)}; endproperty
  a_priv_rd: assert property (p_priv_rd) else $error("privilege read wrong");
  property p_ps_rd; s_rd(OFF_PRESCALE) |=> rsp_rdata[8:0] == $past(sh_q.ps); endproperty
  a_ps_rd: assert property (p_ps_rd) else $error("prescale read wrong");
endmodule : ccr_chk
`default_nettype wire

// ---- ccr_clk_div.sv ----
// Glitch-free divide-by-(ratio+1) tick generator that switches ratio at period boundaries.
`timescale 1ns/1ps
`default_nettype none
module ccr_clk_div #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         advance,
  input  wire logic [W-1:0] ratio,
  // Results
  output logic              tick,
  output logic [W-1:0]      cur_ratio
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] ratio;
    logic         tick;
  } ccr_div_s;

  ccr_div_s s_q;
  ccr_div_s s_d;

  // A new ratio is only loaded when a whole period has ended, so no short phase occurs.
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (advance)
    begin
      if (s_q.cnt == s_q.ratio)
      begin
        s_d.cnt   = '0;
        s_d.ratio = ratio;
        s_d.tick  = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick      = s_q.tick;
  assign cur_ratio = s_q.ratio;
endmodule : ccr_clk_div
`default_nettype wire

// ---- ccr_dev.sv ----
// Clock ratio controller: register file, prescaler, domain dividers and change sequencer.
//
// How it works
// - Registers are 64-bit, aligned accesses only.
// - Unmapped reads give zero, writes dropped.
// - Per-domain local set, window reaches others.
// - Up to eight requestors: cores or io units.
// - Privilege register 0x120: cores 5:0, io units 17:16.
// - Privilege resets to all requestors enabled.
// - Writes from unprivileged requestor are ignored.
// - Domains coherent or not; off at reset.
// - Coherence input level shows in bit 11.
// - No cacheable accesses while coherence off.
// - Flush caches before disabling coherence.
// - Writing one at 0x2008 enables coherence.
// - One prescaler feeds every domain divider.
// - Prescale code changes only with bit 8.
// - Code N divides the clock by N+1.
// - Read-only field shows prescale ratio in effect.
// - Prescaler disabled and undivided after reset.
// - Value 0x103 enables prescaler, divide by four.
// - Domain ratio 1:1 to 1:8 at 0x18.
// - Coherence manager domain allows 1:1 or 1:2.
// - Bit 8 applies ratios; bit 10 shows busy.
// - Change delay in bits 29:20, default 80.
`timescale 1ns/1ps
`default_nettype none
module ccr_dev
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Register link
  ccr_if.dev                      bus,
  // Coherence pins
  input  wire logic [NUM_DOM-1:0] coherence_on_flag,
  output logic      [NUM_DOM-1:0] coherence_request,
  // Clock outputs
  output logic                    prescale_tick,
  output logic      [NUM_DOM-1:0] domain_tick,
  output logic                    change_active
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_CORE-1:0]              priv_core;
    logic [1:0]                       priv_iou;
    logic [PS_W-1:0]                  ps_code;
    logic                             ps_en;
    logic                             cc_apply;
    logic [DLY_W-1:0]                 settle_delay;
    logic [DLY_W-1:0]                 settle_cnt;
    ccr_chg_e                         chg;
    logic [NUM_DOM-1:0][RATIO_W-1:0]  ratio_req;
    logic [NUM_DOM-1:0][RATIO_W-1:0]  ratio_live;
    logic [NUM_DOM-1:0]               coh_req;
    logic                             rsp_valid;
    logic [DATA_W-1:0]                rsp_rdata;
  } ccr_dev_s;

  ccr_dev_s s_q;
  ccr_dev_s s_d;

  logic [PS_W-1:0]    ps_eff;
  logic [PS_W-1:0]    ps_cur;
  logic [NUM_DOM-1:0] dom_tick_w;

  // ****************************************
  // Dividers
  // ****************************************
  // The prescaler passes the clock undivided while it is disabled.
  assign ps_eff = s_q.ps_en ? s_q.ps_code : PS_CODE_RESET;

  ccr_clk_div #(
    .W (PS_W)
  ) u_prescale (
    .clk       (clk),
    .rst       (rst),
    .advance   (1'b1),
    .ratio     (ps_eff),
    .tick      (prescale_tick),
    .cur_ratio (ps_cur)
  );

  // Every domain divider steps only on prescaled ticks.
  for (genvar g = 0; g < NUM_DOM; g++)
  begin : g_dom
    ccr_clk_div #(
      .W (RATIO_W)
    ) u_dom (
      .clk       (clk),
      .rst       (rst),
      .advance   (prescale_tick),
      .ratio     (s_q.ratio_live[g]),
      .tick      (dom_tick_w[g]),
      .cur_ratio ()
    );
  end

  // ****************************************
  // Register access and change sequencer
  // ****************************************
  always_comb
  begin
    logic [ADDR_W-1:0] blk;
    logic [ADDR_W-1:0] off;
    logic [ID_W-1:0]   dom;
    logic              dom_ok;
    logic              allowed;
    logic              aligned;
    logic              is_wr;
    logic [DATA_W-1:0] rd;
    allowed = 1'b0;
    blk     = bus.req_addr & BLOCK_MASK;
    off     = bus.req_addr & ~BLOCK_MASK;
    aligned = (bus.req_addr & ALIGN_MASK) == '0;
    dom     = (blk == OTHER_BASE) ? bus.window_sel : bus.req_id;
    dom_ok  = (blk == OTHER_BASE) ? (32'(dom) < NUM_DOM) : (32'(dom) < NUM_CORE);
    if (32'(bus.req_id) < NUM_CORE)
      allowed = s_q.priv_core[bus.req_id];
    else
      allowed = s_q.priv_iou[bus.req_id[0]];
    is_wr = bus.req_valid && bus.req_write && aligned && allowed;
    rd    = '0;
    s_d   = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.rsp_rdata = '0;

    // Sequencer runs first so that a software apply in the same cycle wins.
    unique case (s_q.chg)
      CCR_IDLE:
      begin
        if (s_q.cc_apply)
        begin
          s_d.ratio_live = s_q.ratio_req;
          s_d.settle_cnt = s_q.settle_delay;
          s_d.chg        = CCR_SETTLE;
        end
      end
      CCR_SETTLE:
      begin
        if (s_q.settle_cnt == '0)
        begin
          s_d.cc_apply = 1'b0;
          s_d.chg      = CCR_IDLE;
        end
        else
        begin
          s_d.settle_cnt = s_q.settle_cnt - DLY_W'(1);
        end
      end
    endcase

    if (aligned && blk == GLOBAL_BASE)
    begin
      unique case (off)
        OFF_CC_CTL:
        begin
          rd[CC_APPLY_BIT]                    = s_q.cc_apply;
          rd[CC_ACTIVE_BIT]                   = (s_q.chg == CCR_SETTLE);
          rd[CHG_DELAY_LSB +: DLY_W]          = s_q.settle_delay;
          if (is_wr)
          begin
            if (bus.req_wdata[CC_APPLY_BIT])
              s_d.cc_apply = 1'b1;
            s_d.settle_delay = bus.req_wdata[CHG_DELAY_LSB +: DLY_W];
          end
        end
        OFF_PRESCALE:
        begin
          rd[PS_W-1:0]            = s_q.ps_code;
          rd[PS_EN_BIT]           = s_q.ps_en;
          rd[PS_CUR_LSB +: PS_W]  = ps_cur;
          if (is_wr)
          begin
            s_d.ps_en = bus.req_wdata[PS_EN_BIT];
            if (s_q.ps_en || bus.req_wdata[PS_EN_BIT])
              s_d.ps_code = bus.req_wdata[PS_W-1:0];
          end
        end
        OFF_PRIV:
        begin
          rd[NUM_CORE-1:0]       = s_q.priv_core;
          rd[IOU_LSB +: 2]       = s_q.priv_iou;
          if (is_wr)
          begin
            s_d.priv_core = bus.req_wdata[NUM_CORE-1:0];
            s_d.priv_iou  = bus.req_wdata[IOU_LSB +: 2];
          end
        end
        default:
        begin
          rd = '0;
        end
      endcase
    end
    else if (aligned && dom_ok && blk != BLOCK_MASK)
    begin
      unique case (off)
        OFF_LOC_STAT:
        begin
          rd[0]            = s_q.coh_req[dom];
          rd[STAT_COH_BIT] = coherence_on_flag[dom];
          if (is_wr)
            s_d.coh_req[dom] = bus.req_wdata[0];
        end
        OFF_LOC_RATIO:
        begin
          rd[RATIO_W-1:0] = s_q.ratio_req[dom];
          if (is_wr)
          begin
            if (32'(dom) == MGR_DOM)
              s_d.ratio_req[dom] = {2'b00, bus.req_wdata[0]};
            else
              s_d.ratio_req[dom] = bus.req_wdata[RATIO_W-1:0];
          end
        end
        default:
        begin
          rd = '0;
        end
      endcase
    end

    if (bus.req_valid && !bus.req_write)
    begin
      s_d.rsp_rdata = rd;
    end
    s_d.rsp_valid = bus.req_valid;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q           <= '0;
      s_q.priv_core <= PRIV_CORE_RESET;
      s_q.priv_iou     <= PRIV_IOU_RESET;
      s_q.settle_delay <= CHG_DELAY_RESET;
      s_q.ps_code   <= PS_CODE_RESET;
      s_q.chg       <= CCR_IDLE;
      s_q.coh_req   <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.req_ready      = 1'b1;
  assign bus.rsp_valid      = s_q.rsp_valid;
  assign bus.rsp_rdata      = s_q.rsp_rdata;
  assign coherence_request  = s_q.coh_req;
  assign domain_tick        = dom_tick_w;
  assign change_active      = (s_q.chg == CCR_SETTLE);

endmodule : ccr_dev
`default_nettype wire

// ---- ccr_host.sv ----
// Requestor end: turns user commands into checked register accesses on the link.
`timescale 1ns/1ps
`default_nettype none
module ccr_host
  import ccr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register link
  ccr_if.host                    bus,
  // User command
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic [ID_W-1:0]   cmd_id,
  input  wire logic [ID_W-1:0]   cmd_window,
  input  wire logic              flush_done,
  output logic                   cmd_ready,
  // User result
  output logic                   cmd_done,
  output logic                   cmd_err,
  output logic      [DATA_W-1:0] cmd_rdata,
  output logic                   cacheable_ok
);
  typedef struct packed {
    ccr_host_e         st;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [ID_W-1:0]   id;
    logic [ID_W-1:0]   win;
    logic              done;
    logic              err;
    logic [DATA_W-1:0] rdata;
    logic              coh_on;
  } ccr_host_s;

  ccr_host_s s_q;
  ccr_host_s s_d;

  always_comb
  begin
    logic [ADDR_W-1:0] off;
    logic              coh_wr;
    off    = cmd_addr & ~BLOCK_MASK;
    coh_wr = cmd_write && off == OFF_LOC_STAT && (cmd_addr & BLOCK_MASK) != GLOBAL_BASE;
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.err  = 1'b0;
    unique case (s_q.st)
      CCR_H_IDLE:
      begin
        if (cmd_valid)
        begin
          if ((cmd_addr & ALIGN_MASK) != '0)
            s_d.err = 1'b1;
          else if (coh_wr && !cmd_wdata[0] && s_q.coh_on && !flush_done)
            s_d.err = 1'b1;
          else
          begin
            s_d.st    = CCR_H_REQ;
            s_d.wr    = cmd_write;
            s_d.addr  = cmd_addr;
            s_d.wdata = cmd_wdata;
            s_d.id    = cmd_id;
            s_d.win   = cmd_window;
            if (cmd_write && cmd_addr == OFF_PRESCALE)
              s_d.wdata[PS_EN_BIT] = 1'b1;
            if (coh_wr)
              s_d.coh_on = cmd_wdata[0];
          end
        end
      end
      CCR_H_REQ:
      begin
        if (bus.req_ready)
          s_d.st = CCR_H_WAIT;
      end
      CCR_H_WAIT:
      begin
        if (bus.rsp_valid)
        begin
          s_d.st    = CCR_H_IDLE;
          s_d.done  = 1'b1;
          s_d.rdata = bus.rsp_rdata;
        end
      end
      default:
      begin
        s_d.st = CCR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign bus.req_valid  = (s_q.st == CCR_H_REQ);
  assign bus.req_write  = s_q.wr;
  assign bus.req_addr   = s_q.addr;
  assign bus.req_wdata  = s_q.wdata;
  assign bus.req_id     = s_q.id;
  assign bus.window_sel = s_q.win;
  assign cmd_ready      = (s_q.st == CCR_H_IDLE);
  assign cmd_done       = s_q.done;
  assign cmd_err        = s_q.err;
  assign cmd_rdata      = s_q.rdata;
  assign cacheable_ok   = s_q.coh_on;
endmodule : ccr_host
`default_nettype wire

// ---- ccr_if.sv ----
// Register request link between requestors and the clock ratio controller.
`timescale 1ns/1ps
`default_nettype none
interface ccr_if
  import ccr_pkg::*;
(
  input wire logic clk
);
  logic              req_valid;
  logic              req_ready;
  logic              req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  logic [ID_W-1:0]   req_id;
  logic [ID_W-1:0]   window_sel;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_rdata;

  modport dev (
    input  clk, req_valid, req_write, req_addr, req_wdata, req_id, window_sel,
    output req_ready, rsp_valid, rsp_rdata
  );
  modport host (
    input  clk, req_ready, rsp_valid, rsp_rdata,
    output req_valid, req_write, req_addr, req_wdata, req_id, window_sel
  );
endinterface : ccr_if
`default_nettype wire

// ---- ccr_pkg.sv ----
// Shared constants and types for the cluster clock ratio control block.
package ccr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_DOM  = 7;
  localparam int NUM_CORE = 6;
  localparam int MGR_DOM  = 6;
  localparam int NUM_REQ  = 8;
  localparam int ADDR_W   = 15;
  localparam int DATA_W   = 64;
  localparam int ID_W     = 3;
  localparam int RATIO_W  = 3;
  localparam int PS_W     = 8;
  localparam int DLY_W    = 10;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [ADDR_W-1:0] BLOCK_MASK    = 15'h6000;
  localparam logic [ADDR_W-1:0] GLOBAL_BASE   = 15'h0000;
  localparam logic [ADDR_W-1:0] LOCAL_BASE    = 15'h2000;
  localparam logic [ADDR_W-1:0] OTHER_BASE    = 15'h4000;
  localparam logic [ADDR_W-1:0] ALIGN_MASK    = 15'h0007;
  localparam logic [ADDR_W-1:0] OFF_CC_CTL    = 15'h0028;
  localparam logic [ADDR_W-1:0] OFF_PRESCALE  = 15'h0048;
  localparam logic [ADDR_W-1:0] OFF_PRIV      = 15'h0120;
  localparam logic [ADDR_W-1:0] OFF_LOC_STAT  = 15'h0008;
  localparam logic [ADDR_W-1:0] OFF_LOC_RATIO = 15'h0018;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int IOU_LSB       = 16;
  localparam int PS_EN_BIT     = 8;
  localparam int PS_CUR_LSB    = 16;
  localparam int CC_APPLY_BIT  = 8;
  localparam int CC_ACTIVE_BIT = 10;
  localparam int CHG_DELAY_LSB = 20;
  localparam int STAT_COH_BIT  = 11;
  localparam logic [NUM_CORE-1:0] PRIV_CORE_RESET = 6'h3F;
  localparam logic [1:0]          PRIV_IOU_RESET  = 2'h3;
  localparam logic [DLY_W-1:0]    CHG_DELAY_RESET = 10'h050;
  localparam logic [PS_W-1:0]     PS_CODE_RESET   = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    CCR_IDLE   = 1'b0,
    CCR_SETTLE = 1'b1
  } ccr_chg_e;

  typedef enum logic [1:0] {
    CCR_H_IDLE = 2'b00,
    CCR_H_REQ  = 2'b01,
    CCR_H_WAIT = 2'b10
  } ccr_host_e;

endpackage : ccr_pkg

// ---- test_cluster_clock_ratio_control.sv ----
// Self-checking bench joining the requestor end to the controller end.
`timescale 1ns/1ps
`default_nettype none
module test_cluster_clock_ratio_control
  import ccr_pkg::*;
;
  // ****************************************
  // Ends and link
  // ****************************************
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cmd_valid = 1'b0;
  logic               cmd_write = 1'b0;
  logic [ADDR_W-1:0]  cmd_addr = '0;
  logic [DATA_W-1:0]  cmd_wdata = '0;
  logic [ID_W-1:0]    cmd_id = '0;
  logic [ID_W-1:0]    cmd_window = '0;
  logic               flush_done = 1'b0;
  logic [NUM_DOM-1:0] coh_flag = '0;
  logic               cmd_ready, cmd_done, cmd_err, cacheable_ok, prescale_tick, change_active;
  logic [DATA_W-1:0]  cmd_rdata, rd_v;
  logic [NUM_DOM-1:0] domain_tick, coh_req;
  logic               got_err;
  int                 bad_count = 0;
  int                 checks_done = 0;

  always #12.5 clk = ~clk;

  ccr_if link (.clk);
  ccr_dev ccr_dev_i (.clk, .rst, .bus(link.dev), .coherence_on_flag(coh_flag), .coherence_request(coh_req),
    .prescale_tick, .domain_tick, .change_active);
  ccr_host ccr_host_i (.clk, .rst, .bus(link.host), .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_id,
    .cmd_window, .flush_done, .cmd_ready, .cmd_done, .cmd_err, .cmd_rdata, .cacheable_ok);
  ccr_chk ccr_chk_i (.clk, .rst, .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_write(link.req_write), .req_addr(link.req_addr), .req_wdata(link.req_wdata), .req_id(link.req_id),
    .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cmd(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [ID_W-1:0] id, input logic [ID_W-1:0] win = 3'h0);
    @(posedge clk);
    cmd_valid  <= 1'b1;
    cmd_write  <= w;
    cmd_addr   <= a;
    cmd_wdata  <= d;
    cmd_id     <= id;
    cmd_window <= win;
    do
      @(posedge clk);
    while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    repeat (12)
    begin
      #1;
      if (cmd_done === 1'b1 || cmd_err === 1'b1)
        break;
      @(posedge clk);
    end
    got_err = (cmd_err === 1'b1);
    rd_v = cmd_rdata;
    if (cmd_done !== 1'b1 && !got_err)
      chk("command end", 64'h0001, 64'h0000);
  endtask : cmd

  function automatic logic tk(input int k);
    return k < 0 ? prescale_tick : domain_tick[k];
  endfunction : tk

  // Skips one tick so the period measured is one begun after any ratio switch.
  task automatic per(input int k, input int e);
    int n;
    n = 0;
    repeat (2)
      do
        @(posedge clk);
      while (tk(k) !== 1'b1);
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tk(k) !== 1'b1 && n < 600);
    chk("tick period", 64'(e), 64'(n));
  endtask : per

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    cmd(1'b0, OFF_PRIV, '0, 3'd7);
    chk("privilege reset", 64'h0003_003F, rd_v);
    cmd(1'b0, OFF_PRESCALE, '0, 3'd0);
    chk("prescale reset", '0, rd_v);
    cmd(1'b0, OFF_CC_CTL, '0, 3'd0);
    chk("change delay reset", 64'h0050, 64'(rd_v[29:20]));
    cmd(1'b0, LOCAL_BASE | OFF_LOC_STAT, '0, 3'd0);
    chk("coherence reset", '0, rd_v);
    per(-1, 1);
  endtask : t_reset

  task automatic t_unmapped;
    cmd(1'b1, 15'h0100, 64'hFFFF_FFFF, 3'd0);
    cmd(1'b0, 15'h0100, '0, 3'd0);
    chk("unpopulated", '0, rd_v);
    cmd(1'b0, 15'h6008, '0, 3'd1);
    chk("spare block", '0, rd_v);
    cmd(1'b0, 15'h0124, '0, 3'd0);
    chk("unaligned refused", 64'h0001, got_err);
  endtask : t_unmapped

  task automatic t_priv;
    cmd(1'b1, OFF_PRIV, 64'h0003_003D, 3'd0);
    cmd(1'b1, OFF_PRIV, '0, 3'd1);
    cmd(1'b1, OFF_PRESCALE, 64'h0103, 3'd1);
    cmd(1'b0, OFF_PRIV, '0, 3'd1);
    chk("privilege kept", 64'h0003_003D, rd_v);
    cmd(1'b0, OFF_PRESCALE, '0, 3'd1);
    chk("prescale kept", '0, rd_v);
    cmd(1'b1, OFF_PRIV, 64'h0001_003F, 3'd6);
    cmd(1'b1, OFF_PRIV, 64'h0003_003F, 3'd7);
    cmd(1'b0, OFF_PRIV, '0, 3'd7);
    chk("io unit refused", 64'h0001_003F, rd_v);
    cmd(1'b1, OFF_PRIV, 64'h0003_003F, 3'd6);
    cmd(1'b0, LOCAL_BASE | OFF_LOC_STAT, '0, 3'd6);
    chk("io unit local", '0, rd_v);
  endtask : t_priv

  task automatic t_coh;
    @(posedge clk);
    coh_flag <= 7'h01;
    cmd(1'b1, LOCAL_BASE | OFF_LOC_STAT, 64'h0001, 3'd0);
    chk("coherence request", 64'h0001, coh_req[0]);
    chk("cacheable allowed", 64'h0001, cacheable_ok);
    cmd(1'b0, LOCAL_BASE | OFF_LOC_STAT, '0, 3'd0);
    chk("coherence status", 64'h0801, rd_v);
    cmd(1'b0, OTHER_BASE | OFF_LOC_STAT, '0, 3'd1, 3'd0);
    chk("window view", 64'h0801, rd_v);
    cmd(1'b1, LOCAL_BASE | OFF_LOC_STAT, '0, 3'd0);
    chk("unflushed disable", 64'h0001, got_err);
    @(posedge clk);
    flush_done <= 1'b1;
    cmd(1'b1, LOCAL_BASE | OFF_LOC_STAT, '0, 3'd0);
    cmd(1'b0, LOCAL_BASE | OFF_LOC_STAT, '0, 3'd0);
    chk("coherence off", 64'h0800, rd_v);
    chk("cacheable barred", '0, cacheable_ok);
  endtask : t_coh

  task automatic t_prescale;
    cmd(1'b1, OFF_PRESCALE, 64'h0103, 3'd0);
    per(-1, 4);
    per(0, 4);
    cmd(1'b0, OFF_PRESCALE, '0, 3'd0);
    chk("ratio in effect", 64'h0003, 64'(rd_v[23:16]));
    cmd(1'b1, OFF_PRESCALE, 64'h01FF, 3'd0);
    per(-1, 256);
    cmd(1'b1, OFF_PRESCALE, 64'h0100, 3'd0);
    per(-1, 1);
  endtask : t_prescale

  task automatic t_ratio;
    int n;
    n = 0;
    cmd(1'b1, LOCAL_BASE | OFF_LOC_RATIO, 64'h0003, 3'd0);
    cmd(1'b1, OTHER_BASE | OFF_LOC_RATIO, 64'h0007, 3'd0, 3'd1);
    cmd(1'b1, OTHER_BASE | OFF_LOC_RATIO, 64'h0007, 3'd0, 3'd6);
    cmd(1'b0, OTHER_BASE | OFF_LOC_RATIO, '0, 3'd0, 3'd6);
    chk("manager ratio", 64'h0001, rd_v);
    per(0, 1);
    cmd(1'b1, OFF_CC_CTL, 64'h0500_0100, 3'd0);
    cmd(1'b0, OFF_CC_CTL, '0, 3'd0);
    chk("change busy", 64'h0500_0500, rd_v);
    while (change_active === 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    cmd(1'b0, OFF_CC_CTL, '0, 3'd0);
    chk("change done", 64'h0500_0000, rd_v);
    per(0, 4);
    per(1, 8);
    per(6, 2);
  endtask : t_ratio

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  initial
  begin
    #(25 * 30000);
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_unmapped();
    t_priv();
    t_coh();
    t_prescale();
    t_ratio();
    summarize();
  end
endmodule : test_cluster_clock_ratio_control
`default_nettype wire
